// *** logic/cs_wait_counter.sv ***
// counts chip-select wait states for one memory access
// assumes start pulses once per access and clears when the access ends
`timescale 1ns/100ps
module cs_wait_counter #(
  parameter int CountW = 4
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clkEn,
  input  wire logic              start,
  input  wire logic              accessEnd,
  input  wire logic [CountW-1:0] waitCount,
  output logic                   waitActive
);
  logic [CountW-1:0] remain_r;
  logic [CountW-1:0] remain_nxt;

  // fewer than four bits cannot hold the eight-wait reset count
  if (CountW < 4) begin : gBadCountW
    $error("cs_wait_counter needs at least 4 bits for 8 waits");
  end

  // load on start, then count down one wait per clock
  always_comb begin
    remain_nxt = remain_r;
    if (accessEnd) begin
      remain_nxt = '0;
    end else if (start) begin
      remain_nxt = waitCount;
    end else if (remain_r != '0) begin
      remain_nxt = remain_r - CountW'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remain_r <= '0;
    end else if (clkEn) begin
      remain_r <= remain_nxt;
    end
  end

  assign waitActive = (remain_r != '0);
endmodule

// *** logic/sys_cfg_pkg.sv ***
// package for the configuration, chip-select and wait-state block
// assumes an 8-bit i/o register port decoded on the low eight address bits
package sys_cfg_pkg;
  // register offsets (low eight i/o address bits)
  localparam logic [7:0] OffsWaitCtl   = 8'hd8;
  localparam logic [7:0] OffsRamUpper  = 8'he6;
  localparam logic [7:0] OffsRamLower  = 8'he7;
  localparam logic [7:0] OffsRomBound  = 8'he8;
  localparam logic [7:0] OffsSysConfig = 8'hef;
  // reset values
  localparam logic [7:0] RstBoundary   = 8'hff;
  localparam logic [7:0] RstWaitCtl    = 8'h77;
  localparam logic [7:0] RstSysConfig  = 8'h00;
  // system configuration field positions
  localparam int CfgPortC     = 7;
  localparam int CfgPortBHi   = 6;
  localparam int CfgPortBLo   = 5;
  localparam int CfgEmuDir    = 4;
  localparam int CfgRomOff    = 3;
  localparam int CfgTriHi     = 2;
  localparam int CfgTriLo     = 1;
  localparam int CfgDaisy     = 0;
  // wait control field positions
  localparam int WaitRamEn    = 7;
  localparam int WaitRamLsb   = 4;
  localparam int WaitRomEn    = 3;
  localparam int WaitRomLsb   = 0;
  localparam int WaitFieldW   = 3;
  // tri-muxed pin groups
  typedef enum logic [1:0] {TriDma, TriChanB, TriHost} tri_sel_e;
  // bus cycle kinds seen by the decoder
  typedef enum logic [2:0] {
    CycIdle, CycMemRd, CycMemWr, CycIoRdOn, CycIoRdOff, CycIoWr, CycRefresh
  } cyc_e;
endpackage

// *** logic/system_config_chip_select_wait.sv ***
// system configuration, rom/ram chip selects and chip-select wait generator
// assumes cpu cycle kind, address and i/o strobes arrive synchronous to clk
// assumes the pin multiplexers, serial channels and ports sit outside this block
`timescale 1ns/100ps

// Overview of operation
// - config bit 7 one routes shared pins to port C, else channel A.
// - config bit 6 one gives port B bits 7-5, else async channel 1.
// - config bit 5 one gives port B bits 4-0, else async channel 0.
// - config bit 4 enables emulator mode exporting internal bus transfers.
// - outside sleep or halt, data bus driven on writes and sampled on memory and off-chip i/o reads; floated on refresh, idle, sleep and halt.
// - config bit 3 one holds rom select inactive; zero enables it.
// - config bits 2:1 choose dma/clocked serial, channel B, or host pins.
// - config bit 1 picks mode 0 serial and port, or mode 1 host emulation.
// - config bit 0 orders serial controller and host emulation interrupt priority.
// - both interrupt sources share external interrupt zero line.
// - ram select when lower boundary <= A19-A12 <= upper boundary.
// - decode uses cpu address bit 18 before timer multiplexing.
// - overlapping ranges assert only rom select.
// - rom select covers zero up to rom boundary inclusive.
// - all three boundary registers reset to all ones.
// - wait register holds ram enable, ram count, rom enable, rom count.
// - reset clears both wait enables and selects eight waits each.
// - dedicated waits only on accesses hitting rom or ram select.
// - waits inserted are the larger of cpu and chip-select counts.
// - both selects are driven high during sleep or halt.
module system_config_chip_select_wait
  import sys_cfg_pkg::*;
#(
  parameter int AddrW = 20
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clkEn,
  // register port
  input  wire logic [7:0] ioAddr,
  input  wire logic [7:0] ioWrData,
  input  wire logic       ioWrite,
  input  wire logic       ioRead,
  output logic [7:0]      ioRdData,
  output logic            ioHit,
  // cpu cycle
  input  wire logic [2:0] cycleKind,
  input  wire logic [AddrW-1:0] cpuAddr,
  input  wire logic       cycleStart,
  input  wire logic       cycleEnd,
  input  wire logic       sleepOrHalt,
  input  wire logic [3:0] cpuWaitCount,
  output logic            waitRequest,
  output logic [3:0]      waitsInserted,
  // chip selects
  output logic            rom_select_n,
  output logic            ram_select_n,
  // data bus direction
  output logic            dataBusDriveEn,
  output logic            dataBusSample,
  output logic            emulator_bus_direction,
  // pin multiplexing
  output logic            portCSelect,
  output logic            portBHiSelect,
  output logic            portBLoSelect,
  output logic [1:0]      triPinGroup,
  output logic            hostEmulationEnable,
  output logic            chanBOutputsEnable,
  output logic            parallelPortEnable,
  // interrupts
  input  wire logic       serialIrq,
  input  wire logic       hostIrq,
  input  wire logic       serialIeiChain,
  output logic            serialIei,
  output logic            hostIei,
  output logic            external_interrupt_zero_n
);
  // register file, one byte of flops per offset
  logic [7:0] sysCfg_r;
  logic [7:0] sysCfg_nxt;
  logic [7:0] ramUpper_r;
  logic [7:0] ramUpper_nxt;
  logic [7:0] ramLower_r;
  logic [7:0] ramLower_nxt;
  logic [7:0] romBound_r;
  logic [7:0] romBound_nxt;
  logic [7:0] waitCtl_r;
  logic [7:0] waitCtl_nxt;
  logic [7:0] rdData_nxt;
  // decode and wait bookkeeping
  logic       romHit;
  logic       ramHit;
  logic       memCycle;
  logic [7:0] addrPage;
  logic [3:0] csWaits;
  logic [3:0] waitMax_r;
  logic [3:0] waitMax_nxt;
  logic       csWaitEn;
  logic       csWaitActive;
  cyc_e       cyc;

  // the page compare is tied to address bits 19 to 12; other widths are refused
  if (AddrW != 20) begin : gBadAddrW
    $error("address width must be 20 for the page compare");
  end

  // decode of a register offset, shared by read and write paths
  function automatic logic isReg(input logic [7:0] a, input logic [7:0] offs);
    return a == offs;
  endfunction

  // inclusive page window, shared by the rom and ram compares
  function automatic logic inRange(input logic [7:0] p, input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction

  // wait count field to number of waits
  // all ones gives eight waits, the reset setting
  function automatic logic [3:0] fieldWaits(input logic [2:0] f);
    return {1'b0, f} + 4'h1;
  endfunction

  // code 7 is illegal and falls to the float default below
  assign cyc = cyc_e'(cycleKind);
  // lets the outer i/o decoder keep other devices off the bus
  assign ioHit = isReg(ioAddr, OffsWaitCtl) | isReg(ioAddr, OffsRamUpper)
               | isReg(ioAddr, OffsRamLower) | isReg(ioAddr, OffsRomBound)
               | isReg(ioAddr, OffsSysConfig);

  // register writes and read mux
  // a read in the write cycle returns the old value
  always_comb begin
    sysCfg_nxt   = sysCfg_r;
    ramUpper_nxt = ramUpper_r;
    ramLower_nxt = ramLower_r;
    romBound_nxt = romBound_r;
    waitCtl_nxt  = waitCtl_r;
    rdData_nxt   = ioRdData;
    if (ioWrite) begin
      if (isReg(ioAddr, OffsSysConfig)) sysCfg_nxt = ioWrData;
      if (isReg(ioAddr, OffsRamUpper))  ramUpper_nxt = ioWrData;
      if (isReg(ioAddr, OffsRamLower))  ramLower_nxt = ioWrData;
      if (isReg(ioAddr, OffsRomBound))  romBound_nxt = ioWrData;
      if (isReg(ioAddr, OffsWaitCtl))   waitCtl_nxt = ioWrData;
    end
    if (ioRead) begin
      rdData_nxt = 8'h00; // unmapped offsets read zero
      if (isReg(ioAddr, OffsSysConfig)) rdData_nxt = sysCfg_r;
      if (isReg(ioAddr, OffsRamUpper))  rdData_nxt = ramUpper_r;
      if (isReg(ioAddr, OffsRamLower))  rdData_nxt = ramLower_r;
      if (isReg(ioAddr, OffsRomBound))  rdData_nxt = romBound_r;
      if (isReg(ioAddr, OffsWaitCtl))   rdData_nxt = waitCtl_r;
    end
  end

  // rom window spans all memory out of reset so boot code is found
  // boundaries reset to all ones
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysCfg_r   <= RstSysConfig;
      ramUpper_r <= RstBoundary;
      ramLower_r <= RstBoundary;
      romBound_r <= RstBoundary;
      waitCtl_r  <= RstWaitCtl;
      ioRdData   <= 8'h00;
    end else if (clkEn) begin
      sysCfg_r   <= sysCfg_nxt;
      ramUpper_r <= ramUpper_nxt;
      ramLower_r <= ramLower_nxt;
      romBound_r <= romBound_nxt;
      waitCtl_r  <= waitCtl_nxt;
      ioRdData   <= rdData_nxt;
    end
  end

  // page taken from cpu address, bit 18 before timer mux
  assign addrPage = cpuAddr[19:12];
  // refresh carries an address too, so it is kept out of the decode
  // memory cycles only
  assign memCycle = (cyc == CycMemRd) || (cyc == CycMemWr);

  // rom floor is fixed at zero; only its ceiling is stored
  // chip-select compare; rom wins on overlap
  always_comb begin
    romHit = memCycle && !sysCfg_r[CfgRomOff] && inRange(addrPage, 8'h00, romBound_r);
    ramHit = memCycle && inRange(addrPage, ramLower_r, ramUpper_r) && !romHit;
  end

  // memory stays deselected through power-down
  // selects high in sleep or halt
  assign rom_select_n = !(romHit && !sleepOrHalt);
  assign ram_select_n = !(ramHit && !sleepOrHalt);

  // select is taken as it stands at cycleStart
  // per-select enable and count fields
  // waits only when a select fires
  always_comb begin
    csWaitEn = 1'b0;
    csWaits  = 4'h0;
    if (romHit && waitCtl_r[WaitRomEn]) begin
      csWaitEn = 1'b1;
      csWaits  = fieldWaits(waitCtl_r[WaitRomLsb +: WaitFieldW]);
    end else if (ramHit && waitCtl_r[WaitRamEn]) begin
      csWaitEn = 1'b1;
      csWaits  = fieldWaits(waitCtl_r[WaitRamLsb +: WaitFieldW]);
    end
    // cpu count of zero lets chip-select count govern
    waitMax_nxt = waitMax_r;
    if (cycleStart) begin
      waitMax_nxt = (csWaitEn && csWaits > cpuWaitCount) ? csWaits : cpuWaitCount;
    end
  end

  // merged count stands until the next access starts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitMax_r <= 4'h0;
    end else if (clkEn) begin
      waitMax_r <= waitMax_nxt;
    end
  end

  // counter loaded with the merged count; held low via wait request
  // merged count goes straight in so the first wait is the cycle after start
  cs_wait_counter #(.CountW(4)) waitGen (
    .clk        (clk),
    .reset_n    (reset_n),
    .clkEn      (clkEn),
    .start      (cycleStart && !sleepOrHalt),
    .accessEnd  (cycleEnd),
    .waitCount  (waitMax_nxt),
    .waitActive (csWaitActive)
  );
  assign waitRequest   = csWaitActive;
  assign waitsInserted = waitMax_r;

  // data bus direction per cycle kind
  // drive on writes, float on refresh and idle
  always_comb begin
    dataBusDriveEn = 1'b0;
    dataBusSample  = 1'b0;
    unique case (cyc)
      CycMemWr, CycIoWr: dataBusDriveEn = 1'b1;
      CycMemRd, CycIoRdOff: dataBusSample = 1'b1;
      CycIoRdOn: dataBusDriveEn = sysCfg_r[CfgEmuDir];
      CycIdle, CycRefresh: dataBusDriveEn = 1'b0;
      default: dataBusDriveEn = 1'b0; // unused cycle codes float
    endcase
    // power-down floats the bus whatever the cycle kind
    if (sleepOrHalt) begin
      dataBusDriveEn = 1'b0;
      dataBusSample  = 1'b0;
    end
  end
  assign emulator_bus_direction = sysCfg_r[CfgEmuDir];

  // pin multiplex selects
  // the multiplexers sit outside; these are plain register bits
  // port C versus channel A
  assign portCSelect   = sysCfg_r[CfgPortC];
  // port B high bits versus async 1
  assign portBHiSelect = sysCfg_r[CfgPortBHi];
  // port B low bits versus async 0
  assign portBLoSelect = sysCfg_r[CfgPortBLo];

  // codes 00 and 01 both give the dma and clocked serial group
  // tri-muxed pin group
  always_comb begin
    unique case (sysCfg_r[CfgTriHi:CfgTriLo])
      2'b10:   triPinGroup = TriChanB;
      2'b11:   triPinGroup = TriHost;
      default: triPinGroup = TriDma;
    endcase
  end

  // all three follow one bit, so they never disagree
  // mode 0 or host emulation mode 1
  assign hostEmulationEnable = sysCfg_r[CfgTriLo];
  assign chanBOutputsEnable  = !sysCfg_r[CfgTriLo];
  assign parallelPortEnable  = !sysCfg_r[CfgTriLo];

  // a pending higher request holds the lower one off until it clears
  // daisy-chain order; higher party passes enable when quiet
  always_comb begin
    if (sysCfg_r[CfgDaisy]) begin
      hostIei   = serialIeiChain;
      serialIei = serialIeiChain && !hostIrq;
    end else begin
      serialIei = serialIeiChain;
      hostIei   = serialIeiChain && !serialIrq;
    end
  end

  // any enabled pending source pulls the line low
  // one shared interrupt line, active low
  assign external_interrupt_zero_n = !((serialIrq && serialIei) || (hostIrq && hostIei));
endmodule

// *** tb/memory_pair.sv ***
// external rom and ram devices seen through their active-low selects
// assumes the selects settle within the cycle that drives them
`timescale 1ns/100ps
module memory_pair (
  input  wire logic       clk,
  input  wire logic       rom_select_n,
  input  wire logic       ram_select_n,
  output logic [1:0]      selDev
);
  // which device answers, bit 1 ram and bit 0 rom; both set means a clash
  assign selDev = {~ram_select_n, ~rom_select_n};
endmodule

// *** tb/sys_cfg_props.sv ***
// port assertions for the configuration and chip-select block
// assumes one clock domain and the async active-low reset
`timescale 1ns/100ps
module sys_cfg_props
  import sys_cfg_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       clkEn,
  input wire logic [2:0] cycleKind,
  input wire logic       cycleStart,
  input wire logic       cycleEnd,
  input wire logic       sleepOrHalt,
  input wire logic [3:0] cpuWaitCount,
  input wire logic       waitRequest,
  input wire logic       rom_select_n,
  input wire logic       ram_select_n,
  input wire logic       dataBusDriveEn,
  input wire logic       dataBusSample,
  input wire logic       emulator_bus_direction,
  input wire logic       hostEmulationEnable,
  input wire logic       parallelPortEnable,
  input wire logic       chanBOutputsEnable,
  input wire logic       serialIrq,
  input wire logic       hostIrq,
  input wire logic       serialIeiChain,
  input wire logic       external_interrupt_zero_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // an access that must raise waits since the cpu count alone is nonzero
  sequence startS;
    clkEn && cycleStart && !sleepOrHalt && !cycleEnd && cpuWaitCount != 4'h0;
  endsequence
  sequence riseS;
    $rose(waitRequest);
  endsequence
  sel_excl_a: assert property (rom_select_n || ram_select_n)
    else $error("both selects low");
  sel_memonly_a: assert property (
    !(cycleKind == CycMemRd || cycleKind == CycMemWr) |-> rom_select_n && ram_select_n)
    else $error("select outside memory cycle");
  sel_sleep_a: assert property (sleepOrHalt |-> rom_select_n && ram_select_n)
    else $error("select low in sleep");
  bus_write_a: assert property (
    !sleepOrHalt && (cycleKind == CycMemWr || cycleKind == CycIoWr)
      |-> dataBusDriveEn && !dataBusSample)
    else $error("write not driven");
  bus_float_a: assert property (
    (cycleKind == CycIdle || cycleKind == CycRefresh) |-> !dataBusDriveEn && !dataBusSample)
    else $error("bus not floated");
  emu_read_a: assert property (
    !sleepOrHalt && cycleKind == CycIoRdOn |-> dataBusDriveEn == emulator_bus_direction)
    else $error("on-chip read direction");
  mode_split_a: assert property (
    hostEmulationEnable != parallelPortEnable && chanBOutputsEnable == parallelPortEnable)
    else $error("mode enables disagree");
  irq_share_a: assert property (
    serialIrq && serialIeiChain && !hostIrq |-> !external_interrupt_zero_n)
    else $error("serial irq not on line");
  wait_start_a: assert property (startS |=> waitRequest)
    else $error("no wait after start");
  wait_bound_a: assert property (riseS |-> ##[1:15] !waitRequest)
    else $error("wait too long");
endmodule
bind system_config_chip_select_wait sys_cfg_props props (.clk, .reset_n, .clkEn, .cycleKind,
  .cycleStart, .cycleEnd, .sleepOrHalt, .cpuWaitCount, .waitRequest, .rom_select_n,
  .ram_select_n, .dataBusDriveEn, .dataBusSample, .emulator_bus_direction,
  .hostEmulationEnable, .parallelPortEnable, .chanBOutputsEnable, .serialIrq, .hostIrq,
  .serialIeiChain, .external_interrupt_zero_n);

// *** tb/system_config_chip_select_wait_bench.sv ***
// self-checking bench: registers, pin steering, chip selects and waits
// assumes the package compiles first; one 100 MHz clock
`timescale 1ns/100ps
module system_config_chip_select_wait_bench
  import sys_cfg_pkg::*;
;
  logic clk = 0, reset_n = 0, clkEn = 1, ioWrite = 0, ioRead = 0, s, dr, sm;
  logic cycleStart = 0, cycleEnd = 0, sleepOrHalt = 0;
  logic serialIrq = 0, hostIrq = 0, serialIeiChain = 1;
  logic [7:0] ioAddr = 8'h00, ioWrData = 8'h00, ioRdData, rd, v, n;
  logic [2:0] cycleKind = 3'h0, k, q;
  logic [19:0] cpuAddr = 20'h00000, a;
  logic [3:0] cpuWaitCount = 4'h0, waitsInserted, c;
  logic ioHit, waitRequest, rom_select_n, ram_select_n, dataBusDriveEn, dataBusSample;
  logic emulator_bus_direction, portCSelect, portBHiSelect, portBLoSelect;
  logic hostEmulationEnable, chanBOutputsEnable, parallelPortEnable;
  logic serialIei, hostIei, external_interrupt_zero_n;
  logic [1:0] triPinGroup, selDev, d;
  logic [7:0] cfg = 8'h00, ub = 8'hff, lb = 8'hff, rb = 8'hff, wc = 8'h77;
  logic [7:0] offs [6] = '{OffsWaitCtl, OffsRamUpper, OffsRamLower, OffsRomBound,
                           OffsSysConfig, 8'hd9};
  integer seed = 89917, miscompares = 0, checked = 0, cyc = 0, i;

  system_config_chip_select_wait dut (.clk, .reset_n, .clkEn, .ioAddr, .ioWrData, .ioWrite,
    .ioRead, .ioRdData, .ioHit, .cycleKind, .cpuAddr, .cycleStart, .cycleEnd, .sleepOrHalt,
    .cpuWaitCount, .waitRequest, .waitsInserted, .rom_select_n, .ram_select_n,
    .dataBusDriveEn, .dataBusSample, .emulator_bus_direction, .portCSelect, .portBHiSelect,
    .portBLoSelect, .triPinGroup, .hostEmulationEnable, .chanBOutputsEnable,
    .parallelPortEnable, .serialIrq, .hostIrq, .serialIeiChain, .serialIei, .hostIei,
    .external_interrupt_zero_n);
  memory_pair mem (.clk, .rom_select_n, .ram_select_n, .selDev);

  always #5 clk = ~clk;
  // hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one write, shadowing what the register should now hold
  task wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    ioAddr <= ad;
    ioWrData <= dt;
    ioWrite <= 1'b1;
    @(posedge clk);
    ioWrite <= 1'b0;
    case (ad)
      OffsWaitCtl: wc = dt;
      OffsRamUpper: ub = dt;
      OffsRamLower: lb = dt;
      OffsRomBound: rb = dt;
      OffsSysConfig: cfg = dt;
      default: ;
    endcase
  endtask
  task rdr(input logic [7:0] ad);
    @(posedge clk);
    ioAddr <= ad;
    ioRead <= 1'b1;
    @(posedge clk);
    ioRead <= 1'b0;
    @(negedge clk);
    rd = ioRdData;
  endtask
  function logic [7:0] regv(input logic [7:0] ad);
    case (ad)
      OffsWaitCtl: return wc;
      OffsRamUpper: return ub;
      OffsRamLower: return lb;
      OffsRomBound: return rb;
      OffsSysConfig: return cfg;
      default: return 8'h00;
    endcase
  endfunction
  // expected selects, bit 1 ram and bit 0 rom; rom wins any overlap
  function logic [1:0] dec(input logic [2:0] kd, input logic [19:0] ad, input logic sl);
    logic m, ro;
    m = !sl && (kd == CycMemRd || kd == CycMemWr);
    ro = m && !cfg[3] && ad[19:12] <= rb;
    return {m && !ro && ad[19:12] <= ub && ad[19:12] >= lb, ro};
  endfunction
  function logic [3:0] waits(input logic [1:0] hit, input logic [3:0] cw);
    logic [3:0] w;
    w = cw;
    if (hit[0] && wc[3] && {1'b0, wc[2:0]} + 4'h1 > w) w = {1'b0, wc[2:0]} + 4'h1;
    if (hit[1] && wc[7] && {1'b0, wc[6:4]} + 4'h1 > w) w = {1'b0, wc[6:4]} + 4'h1;
    return w;
  endfunction

  // daisy chain: the higher party passes the enable down only while quiet
  function logic [2:0] irq(input logic si, input logic hi, input logic ch);
    logic se, he;
    se = cfg[0] ? ch && !hi : ch;
    he = cfg[0] ? ch : ch && !si;
    return {!((si && se) || (hi && he)), he, se};
  endfunction

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // reset values first, then random write and read back, unmapped too
    for (i = 0; i < 36; i++) begin
      if (i >= 6) wr(offs[i % 6], $random(seed));
      rdr(offs[i % 6]);
      chk("register", rd, regv(offs[i % 6]));
      chk("hit", ioHit, offs[i % 6] != 8'hd9);
    end
    // clock enable low: a write must not land
    v = lb;
    @(posedge clk);
    clkEn <= 1'b0;
    wr(OffsRamLower, ~v);
    lb = v;
    @(posedge clk);
    clkEn <= 1'b1;
    rdr(OffsRamLower);
    chk("frozen", rd, lb);
    // steering and decode; every triple-pin code is visited
    for (i = 0; i < 240; i++) begin
      if (i % 40 == 0) begin
        v = $random(seed);
        v[2:1] = 2'(i / 40);
        wr(OffsSysConfig, v);
        wr(OffsRomBound, $random(seed));
        wr(OffsRamLower, $random(seed));
        wr(OffsRamUpper, $random(seed));
        @(negedge clk);
        chk("portC", portCSelect, cfg[7]);
        chk("portBHi", portBHiSelect, cfg[6]);
        chk("portBLo", portBLoSelect, cfg[5]);
        chk("emu", emulator_bus_direction, cfg[4]);
        chk("tri", triPinGroup, cfg[2] ? (cfg[1] ? 2'h2 : 2'h1) : 2'h0);
        chk("host", hostEmulationEnable, cfg[1]);
        chk("port", parallelPortEnable, !cfg[1]);
        chk("chanB", chanBOutputsEnable, !cfg[1]);
      end
      k = 3'($unsigned($random(seed)) % 7);
      a = $random(seed);
      if (i % 3 == 0) a[19:12] = i % 2 ? rb : lb;
      s = ($random(seed) & 3) == 0;
      @(posedge clk);
      cycleKind <= k;
      cpuAddr <= a;
      sleepOrHalt <= s;
      serialIrq <= $random(seed);
      hostIrq <= $random(seed);
      serialIeiChain <= $random(seed);
      @(negedge clk);
      d = dec(k, a, s);
      chk("rom", rom_select_n, !d[0]);
      chk("ram", ram_select_n, !d[1]);
      chk("device", selDev, d);
      // power-down floats the bus whatever the cycle kind
      dr = !s && (k == CycMemWr || k == CycIoWr || (k == CycIoRdOn && cfg[4]));
      sm = !s && (k == CycMemRd || k == CycIoRdOff);
      q = irq(serialIrq, hostIrq, serialIeiChain);
      chk("drive", dataBusDriveEn, dr);
      chk("sample", dataBusSample, sm);
      chk("irq", {external_interrupt_zero_n, hostIei, serialIei}, q);
    end
    // waits on single accesses; cpu count zero in half of them
    for (i = 0; i < 40; i++) begin
      wr(OffsWaitCtl, $random(seed));
      a = $random(seed);
      c = i % 2 ? 4'h0 : 4'($random(seed));
      d = dec(CycMemRd, a, 1'b0);
      @(posedge clk);
      cycleKind <= CycMemRd;
      cpuAddr <= a;
      sleepOrHalt <= 1'b0;
      cpuWaitCount <= c;
      cycleStart <= 1'b1;
      @(posedge clk);
      cycleStart <= 1'b0;
      @(negedge clk);
      chk("merged", waitsInserted, waits(d, c));
      for (n = 0; n < 20 && waitRequest === 1'b1; n++) @(negedge clk);
      chk("waits", n, waits(d, c));
      @(posedge clk);
      cycleEnd <= 1'b1;
      @(posedge clk);
      cycleEnd <= 1'b0;
      cycleKind <= CycIdle;
    end
    // mid-run reset brings every register back to its power-on value
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    {cfg, ub, lb, rb, wc} = {RstSysConfig, RstBoundary, RstBoundary, RstBoundary, RstWaitCtl};
    for (i = 0; i < 6; i++) begin
      rdr(offs[i]);
      chk("reset", rd, regv(offs[i]));
    end
    test_done();
  end
endmodule
